//--- tb/icd_idle_detector_assertions.sv
// Purpose: port checks for the idle channel detector
// Assumes: one clock domain, async active-high reset
// Notes:   bound into every detector instance
`default_nettype none
module icd_idle_checker #(
   parameter CH_BITS = 5,
   parameter NUM_CH  = 32
) (
   input wire logic               clock,
   input wire logic               sys_rst,
   input wire logic               regWrite,
   input wire logic               regRead,
   input wire logic [7:0]         regRdData,
   input wire logic               rcvValid,
   input wire logic               sndValid,
   input wire logic               disableStrobe,
   input wire logic [CH_BITS-1:0] disableChan,
   input wire logic               coefReset,
   input wire logic               cancelBypass,
   input wire logic               speechReset,
   input wire logic [NUM_CH-1:0]  chanDisabled,
   input wire logic               monitorPinOne,
   input wire logic               monitorPinTwo,
   input wire logic               irq
);
   timeunit 1ns;
   timeprecision 1ps;
   wire logic anyValid;
   assign anyValid = rcvValid | sndValid;
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   ////////////////////////////////////////
   a_read_quiet: assert property (!$past(regRead) |-> regRdData == 8'h00)
      else $error("read data outside its slot");
   a_disable_trio: assert property (coefReset == cancelBypass && coefReset == speechReset)
      else $error("disable outputs disagree");
   a_strobe_cause: assert property (disableStrobe |-> $past(anyValid))
      else $error("strobe without byte");
   a_pin_one: assert property (monitorPinOne |-> coefReset)
      else $error("pin one high without idle");
   a_pin_two: assert property (monitorPinTwo |-> coefReset)
      else $error("pin two high without idle");
   a_irq_cause: assert property ($rose(irq) |-> disableStrobe || $past(regWrite))
      else $error("irq rose without event");
   a_vector_set: assert property (disableStrobe && coefReset |=> chanDisabled[$past(disableChan)])
      else $error("idle channel not disabled");
   a_level_hold: assert property (!$past(anyValid) && !$past(regWrite) && !$past(regWrite, 2)
      |-> $stable(coefReset))
      else $error("idle level moved without byte");
   a_chan_hold: assert property (!$past(anyValid) |-> $stable(disableChan))
      else $error("channel moved without byte");
   c_idle: cover property (disableStrobe && coefReset);
   c_leave: cover property ($fell(coefReset));
   c_irq: cover property (irq);
endmodule
bind icd_idle_detector icd_idle_checker #(.CH_BITS(CH_BITS), .NUM_CH(NUM_CH)) chk_u (
   .clock(clock), .sys_rst(sys_rst), .regWrite(regWrite), .regRead(regRead),
   .regRdData(regRdData), .rcvValid(rcvValid), .sndValid(sndValid),
   .disableStrobe(disableStrobe), .disableChan(disableChan), .coefReset(coefReset),
   .cancelBypass(cancelBypass), .speechReset(speechReset), .chanDisabled(chanDisabled),
   .monitorPinOne(monitorPinOne), .monitorPinTwo(monitorPinTwo), .irq(irq));
`default_nettype wire

//--- tb/icd_idle_detector_bench.sv
// Purpose: self-checking bench for the idle channel detector
// Assumes: long frame time so every interval is a few bytes
// Notes:   random masks, references and paths from a fixed seed
`default_nettype none
module icd_idle_detector_bench;
   timeunit 1ns;
   timeprecision 1ps;
   localparam int FR = 32000000;
   localparam int T_US [8] = '{64000, 128000, 512000, 1000000,
                               4100000, 8200000, 32800000, 65500000};
   logic        clock, sys_rst, regWrite, regRead, p;
   logic [7:0]  regAddr, regWrData, regRdData, refByte, msk, b;
   logic [7:0]  rcvByte, sndByte;
   logic [4:0]  rcvChan, sndChan, disableChan, ch;
   logic        rcvValid, sndValid, disableStrobe, coefReset, cancelBypass, speechReset;
   logic        monitorPinOne, monitorPinTwo, irq;
   logic [31:0] chanDisabled;
   int          failCount, cmpCount, cycles, n;
   icd_idle_detector #(.FRAME_US(FR)) dut_u (
      .clock(clock), .sys_rst(sys_rst), .regAddr(regAddr), .regWrData(regWrData),
      .regWrite(regWrite), .regRead(regRead), .regRdData(regRdData),
      .rcvByte(rcvByte), .rcvChan(rcvChan), .rcvValid(rcvValid),
      .sndByte(sndByte), .sndChan(sndChan), .sndValid(sndValid),
      .disableStrobe(disableStrobe), .disableChan(disableChan), .coefReset(coefReset),
      .cancelBypass(cancelBypass), .speechReset(speechReset), .chanDisabled(chanDisabled),
      .monitorPinOne(monitorPinOne), .monitorPinTwo(monitorPinTwo), .irq(irq));
   icd_pcm_source src_u (
      .clock(clock), .rcvByte(rcvByte), .rcvChan(rcvChan), .rcvValid(rcvValid),
      .sndByte(sndByte), .sndChan(sndChan), .sndValid(sndValid));
   ////////////////////////////////////////
   function automatic int thr(input int code);
      return (T_US[code] + FR - 1) / FR;
   endfunction
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      cmpCount++;
      if (got !== exp) begin
         failCount++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      regAddr <= a;
      regWrData <= d;
      regWrite <= 1'b1;
      @(posedge clock);
      regWrite <= 1'b0;
      @(posedge clock);
   endtask
   task automatic rd(input logic [7:0] a, input logic [7:0] exp);
      regAddr <= a;
      regRead <= 1'b1;
      @(posedge clock);
      regRead <= 1'b0;
      #1;
      chk(regRdData, exp);
      @(posedge clock);
   endtask
   task automatic pcm(input logic pth, input logic [4:0] c, input logic [7:0] v,
                      input logic strb, input logic idl);
      src_u.send(pth, c, v);
      #1;
      chk(disableStrobe, strb);
      if (strb) begin
         chk(coefReset, idl);
         chk(cancelBypass & speechReset, idl);
         chk(disableChan, c);
      end
      @(posedge clock);
   endtask
   task summarize;
      if (failCount == 0 && cmpCount > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   ////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #12.5 clock = ~clock;
   end
   always @(posedge clock) begin
      cycles++;
      if (cycles == 5000) begin
         failCount++;
         summarize();
      end
   end
   initial begin
      {regAddr, regWrData, regWrite, regRead, sys_rst} = {8'h00, 8'h00, 3'b001};
      {failCount, cmpCount, cycles} = '0;
      void'($urandom(32'heb7fef70));
      repeat (16) @(posedge clock);
      sys_rst <= 1'b0;
      @(posedge clock);
      rd(8'h32, 8'h1d);
      rd(8'h33, 8'h00);
      rd(8'h34, 8'h55);
      rd(8'h3d, 8'h00);
      wr(8'h34, 8'h12);
      rd(8'h34, 8'h55);
      wr(8'h32, 8'h3f);
      rd(8'h32, 8'h1d);
      wr(8'h3b, 8'h01);
      wr(8'h3a, 8'h01);
      for (int code = 0; code < 8; code++) begin
         p = 1'($urandom);
         ch = 5'($urandom);
         msk = 8'($urandom) & 8'h7f;
         refByte = 8'($urandom);
         wr(8'h32, 8'h00);
         wr(8'h33, msk);
         wr(8'h34, refByte);
         wr(8'h6f, code[0] ? 8'h0f : 8'hf0);
         wr(8'h32, 8'h20 | 8'(code << 2) | {7'h00, p});
         pcm(!p, ch, refByte, 1'b0, 1'b0);
         n = thr(code);
         for (int k = 1; k <= n; k++) begin
            pcm(p, ch, refByte ^ (8'($urandom) & msk), 1'b1, k == n);
         end
         // vector lags the idle result by a cycle; look once it has settled
         @(posedge clock);
         chk(monitorPinOne, code[0]);
         chk(monitorPinTwo, !code[0]);
         chk(chanDisabled, 32'h1 << ch);
         chk(irq, 1'b1);
         rd(8'h38, 8'h01);
         rd(8'h3c, {3'h0, ch});
         rd(8'h39, 8'h01);
         pcm(p, ch, refByte ^ 8'h80, 1'b1, 1'b0);
         rd(8'h39, 8'h02);
         chk(irq, 1'b0);
      end
      wr(8'h32, 8'h00);
      wr(8'h33, 8'h00);
      wr(8'h32, 8'h22);
      b = 8'($urandom);
      pcm(1'b0, 5'h03, b, 1'b1, 1'b0);
      pcm(1'b0, 5'h04, ~b, 1'b1, 1'b0);
      pcm(1'b0, 5'h03, b, 1'b1, 1'b1);
      pcm(1'b0, 5'h04, b, 1'b1, 1'b0);
      wr(8'h32, 8'h02);
      @(posedge clock);
      chk(chanDisabled, 32'h0);
      pcm(1'b0, 5'h03, b, 1'b0, 1'b0);
      chk(coefReset, 1'b0);
      summarize();
   end
endmodule
`default_nettype wire

//--- tb/icd_pcm_source.sv
// Purpose: pcm byte source for the receive and send paths
// Assumes: one byte per call, valid for one cycle
// Notes:   released byte lines show the inverse of the last byte
`default_nettype none
module icd_pcm_source #(
   parameter CH_BITS = 5
) (
   input  wire logic               clock,
   output var  logic [7:0]         rcvByte,
   output var  logic [CH_BITS-1:0] rcvChan,
   output var  logic               rcvValid,
   output var  logic [7:0]         sndByte,
   output var  logic [CH_BITS-1:0] sndChan,
   output var  logic               sndValid
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      {rcvByte, rcvChan, rcvValid} = '0;
      {sndByte, sndChan, sndValid} = '0;
   end
   // a stale byte would mimic a match, so the line is inverted after use
   task automatic send(input logic pth, input logic [CH_BITS-1:0] c, input logic [7:0] v);
      if (pth) begin
         {sndByte, sndChan, sndValid} <= {v, c, 1'b1};
      end else begin
         {rcvByte, rcvChan, rcvValid} <= {v, c, 1'b1};
      end
      @(posedge clock);
      sndValid <= 1'b0;
      rcvValid <= 1'b0;
      if (pth) sndByte <= ~v;
      else rcvByte <= ~v;
   endtask
endmodule
`default_nettype wire

//--- verilog/icd_chan_state.v
// Purpose: per-channel store of previous byte, match timer and idle state
// Assumes: one read-modify-write per clock, read is combinational
// Notes:   byte and timer arrays carry no reset; primed bit hides stale data
`default_nettype none

module icd_chan_state #(
   parameter CH_BITS = 5,
   parameter NUM_CH  = 32,
   parameter T_BITS  = 20
) (
   input  wire                clock,
   input  wire                sys_rst,
   input  wire [CH_BITS-1:0]  rdChan,
   output wire [7:0]          rdPrev,
   output wire [T_BITS-1:0]   rdTimer,
   output wire                rdPrimed,
   output wire [NUM_CH-1:0]   idleVector,
   input  wire                wrEn,
   input  wire [CH_BITS-1:0]  wrChan,
   input  wire [7:0]          wrPrev,
   input  wire [T_BITS-1:0]   wrTimer,
   input  wire                wrIdle,
   input  wire                clearAll
);

   reg [7:0]        prevMem  [0:NUM_CH-1];
   reg [T_BITS-1:0] timerMem [0:NUM_CH-1];
   reg [NUM_CH-1:0] primed;
   reg [NUM_CH-1:0] idle;

   ////////////////////////////////////////////////////////////////////////////
   // separate state for every timeslot
   assign rdPrev     = prevMem[rdChan];
   assign rdTimer    = primed[rdChan] ? timerMem[rdChan] : {T_BITS{1'b0}};
   assign rdPrimed   = primed[rdChan];
   assign idleVector = idle;

   always @(posedge clock) begin
      if (wrEn) begin
         prevMem[wrChan]  <= wrPrev;
         timerMem[wrChan] <= wrTimer;
      end
   end

   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         primed <= {NUM_CH{1'b0}};
         idle   <= {NUM_CH{1'b0}};
      end else if (clearAll) begin
         primed <= {NUM_CH{1'b0}};
         idle   <= {NUM_CH{1'b0}};
      end else if (wrEn) begin
         primed[wrChan] <= 1'b1;
         idle[wrChan]   <= wrIdle;
      end
   end

endmodule

`default_nettype wire

//--- verilog/icd_idle_detector.v
// Purpose: idle channel detector for the echo canceller pcm paths
// Assumes: pcm bytes arrive with a channel number and a one-cycle valid,
//          on the system clock; one byte per channel per frame
// Notes:   protected registers accept writes only while the unlock bit is set
//
// Functional notes
// - compare byte with previous or reference, masked
// - idle shown in monitor status flag
// - idle indication available on either monitor pin
// - monitor code 0000 routes idle to pin
// - enabled idle disables channel; else detection off
// - interval codes 000-011: 64ms to 1s
// - interval codes 100-111: 4.1s to 65.5s
// - source bit 1: compare with previous byte
// - source bit 0: compare with reference byte
// - path bit: 1 send input, 0 receive
// - mask bit 1 excludes that bit
// - reference byte resets to 55h
// - mask resets 00h; mask, reference write protected
// - config write protected, resets to 1dh
//
// Implementation choice: the plain strobed port.
`default_nettype none
`include "icd_regs.vh"

module icd_idle_detector #(
   parameter CH_BITS  = 5,
   parameter NUM_CH   = 32,
   parameter FRAME_US = `ICD_FRAME_US
) (
   input  wire                clock,
   input  wire                sys_rst,
   // register port
   input  wire [7:0]          regAddr,
   input  wire [7:0]          regWrData,
   input  wire                regWrite,
   input  wire                regRead,
   output reg  [7:0]          regRdData,
   // pcm inputs
   input  wire [7:0]          rcvByte,
   input  wire [CH_BITS-1:0]  rcvChan,
   input  wire                rcvValid,
   input  wire [7:0]          sndByte,
   input  wire [CH_BITS-1:0]  sndChan,
   input  wire                sndValid,
   // channel disable controls
   output reg                 disableStrobe,
   output reg  [CH_BITS-1:0]  disableChan,
   output reg                 coefReset,
   output reg                 cancelBypass,
   output reg                 speechReset,
   output reg  [NUM_CH-1:0]   chanDisabled,
   // monitor pins and interrupt
   output reg                 monitorPinOne,
   output reg                 monitorPinTwo,
   output wire                irq
);

   localparam T_BITS = 20;

   reg  [5:0]          detectorConfig;
   reg  [7:0]          compareBitMask;
   reg  [7:0]          referenceByte;
   reg  [7:0]          monitorConfig;
   reg  [1:0]          irqStatus;
   reg  [1:0]          irqMask;
   reg                 writeUnlock;
   reg  [CH_BITS-1:0]  lastIdleChan;

   wire [7:0]          rdPrev;
   wire [T_BITS-1:0]   rdTimer;
   wire                rdPrimed;
   wire [NUM_CH-1:0]   idleVector;

   ////////////////////////////////////////////////////////////////////////////
   // functions

   // whole frames needed to cover the interval; never below one
   function [T_BITS-1:0] protCount;
      input [2:0] code;
      reg [31:0] timeUs;
      reg [31:0] frames;
      begin
         case (code)
            3'h0: timeUs = `ICD_T_CODE0_US;
            3'h1: timeUs = `ICD_T_CODE1_US;
            3'h2: timeUs = `ICD_T_CODE2_US;
            3'h3: timeUs = `ICD_T_CODE3_US;
            3'h4: timeUs = `ICD_T_CODE4_US;
            3'h5: timeUs = `ICD_T_CODE5_US;
            3'h6: timeUs = `ICD_T_CODE6_US;
            default: timeUs = `ICD_T_CODE7_US;
         endcase
         frames = (timeUs + FRAME_US - 1) / FRAME_US;
         if (frames == 32'h0)
            frames = 32'h1;
         protCount = frames[T_BITS-1:0];
      end
   endfunction

   // masked bits never cause a mismatch
   function bytesMatch;
      input [7:0] value;
      input [7:0] target;
      input [7:0] ignore;
      begin
         bytesMatch = (((value ^ target) & ~ignore) == 8'h00);
      end
   endfunction

   // monitor pin output for one configuration code
   function monitorSelect;
      input [3:0] code;
      input       idleNow;
      begin
         if (code == `ICD_MON_CODE_IDLE)
            monitorSelect = idleNow;
         else
            monitorSelect = 1'b0;
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // configuration fields

   wire          detectEnable = detectorConfig[`ICD_CFG_ENABLE];
   wire [2:0]    intervalSel  = detectorConfig[`ICD_CFG_INTERVAL_HI:`ICD_CFG_INTERVAL_LO];
   wire          sourcePrev   = detectorConfig[`ICD_CFG_SOURCE];
   wire          pathSend     = detectorConfig[`ICD_CFG_PATH];

   ////////////////////////////////////////////////////////////////////////////
   // sample selection and compare

   wire [7:0]         inByte  = pathSend ? sndByte  : rcvByte;
   wire [CH_BITS-1:0] inChan  = pathSend ? sndChan  : rcvChan;
   wire               inValid = pathSend ? sndValid : rcvValid;

   // with no stored byte yet, previous-byte mode cannot match
   wire [7:0]  compareTarget = sourcePrev ? rdPrev : referenceByte;
   wire        targetUsable  = sourcePrev ? rdPrimed : 1'b1;
   wire        byteMatches   = targetUsable && bytesMatch(inByte, compareTarget, compareBitMask);

   wire [T_BITS-1:0] needed = protCount(intervalSel);
   wire              wasIdle = idleVector[inChan];

   reg  [T_BITS-1:0] next_timer;
   reg               next_idle;

   always @* begin
      next_timer = {T_BITS{1'b0}};
      next_idle  = 1'b0;
      if (byteMatches) begin
         if (rdTimer >= needed - 1'b1) begin
            next_timer = rdTimer;
            next_idle  = 1'b1;
         end else begin
            next_timer = rdTimer + 1'b1;
            next_idle  = 1'b0;
         end
      end
   end

   // detection off holds every channel non-idle
   wire stateWrite = inValid && detectEnable;
   wire becameIdle = stateWrite && next_idle && !wasIdle;
   wire leftIdle   = stateWrite && !next_idle && wasIdle;

   icd_chan_state #(
      .CH_BITS (CH_BITS),
      .NUM_CH  (NUM_CH),
      .T_BITS  (T_BITS)
   ) chanState (
      .clock      (clock),
      .sys_rst    (sys_rst),
      .rdChan     (inChan),
      .rdPrev     (rdPrev),
      .rdTimer    (rdTimer),
      .rdPrimed   (rdPrimed),
      .idleVector (idleVector),
      .wrEn       (stateWrite),
      .wrChan     (inChan),
      .wrPrev     (inByte),
      .wrTimer    (next_timer),
      .wrIdle     (next_idle),
      .clearAll   (!detectEnable)
   );

   ////////////////////////////////////////////////////////////////////////////
   // channel disable and monitor outputs

   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         disableStrobe <= 1'b0;
         disableChan   <= {CH_BITS{1'b0}};
         coefReset     <= 1'b0;
         cancelBypass  <= 1'b0;
         speechReset   <= 1'b0;
         chanDisabled  <= {NUM_CH{1'b0}};
         monitorPinOne <= 1'b0;
         monitorPinTwo <= 1'b0;
      end else begin
         disableStrobe <= stateWrite;
         chanDisabled  <= detectEnable ? idleVector : {NUM_CH{1'b0}};
         if (stateWrite) begin
            disableChan   <= inChan;
            coefReset     <= next_idle;
            cancelBypass  <= next_idle;
            speechReset   <= next_idle;
            monitorPinOne <= monitorSelect(monitorConfig[`ICD_MON_ONE_HI:`ICD_MON_ONE_LO],
                                           next_idle);
            monitorPinTwo <= monitorSelect(monitorConfig[`ICD_MON_TWO_HI:`ICD_MON_TWO_LO],
                                           next_idle);
         end else if (!detectEnable) begin
            coefReset     <= 1'b0;
            cancelBypass  <= 1'b0;
            speechReset   <= 1'b0;
            monitorPinOne <= 1'b0;
            monitorPinTwo <= 1'b0;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // register writes

   wire protectedOk = writeUnlock;

   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         detectorConfig <= `ICD_RST_CONFIG;
         compareBitMask <= `ICD_RST_MASK;
         referenceByte  <= `ICD_RST_REFERENCE;
         monitorConfig  <= `ICD_RST_MONCFG;
         irqMask        <= `ICD_RST_IRQ_MASK;
         writeUnlock    <= `ICD_RST_UNLOCK;
      end else if (regWrite) begin
         case (regAddr)
            `ICD_ADDR_CONFIG: begin
               if (protectedOk)
                  detectorConfig <= regWrData[5:0];
            end
            `ICD_ADDR_MASK: begin
               if (protectedOk)
                  compareBitMask <= regWrData;
            end
            `ICD_ADDR_REFERENCE: begin
               if (protectedOk)
                  referenceByte <= regWrData;
            end
            `ICD_ADDR_MONCFG:   monitorConfig <= regWrData;
            `ICD_ADDR_IRQ_MASK: irqMask       <= regWrData[1:0];
            `ICD_ADDR_UNLOCK:   writeUnlock   <= regWrData[0];
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status: a new event in the clearing read cycle survives

   wire       irqClear = regRead && (regAddr == `ICD_ADDR_IRQ_STATUS);
   wire [1:0] irqSet   = {leftIdle, becameIdle};

   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         irqStatus    <= 2'h0;
         lastIdleChan <= {CH_BITS{1'b0}};
      end else begin
         irqStatus <= (irqStatus & {2{~irqClear}}) | irqSet;
         if (becameIdle)
            lastIdleChan <= inChan;
      end
   end

   assign irq = |(irqStatus & irqMask);

   ////////////////////////////////////////////////////////////////////////////
   // register reads, data in the cycle after the strobe

   wire anyIdle = |idleVector;

   always @(posedge clock or posedge sys_rst) begin
      if (sys_rst) begin
         regRdData <= 8'h00;
      end else if (regRead) begin
         case (regAddr)
            `ICD_ADDR_CONFIG:     regRdData <= {2'h0, detectorConfig};
            `ICD_ADDR_MASK:       regRdData <= compareBitMask;
            `ICD_ADDR_REFERENCE:  regRdData <= referenceByte;
            `ICD_ADDR_MONSTAT:    regRdData <= {7'h00, anyIdle};
            `ICD_ADDR_IRQ_STATUS: regRdData <= {6'h00, irqStatus};
            `ICD_ADDR_IRQ_MASK:   regRdData <= {6'h00, irqMask};
            `ICD_ADDR_UNLOCK:     regRdData <= {7'h00, writeUnlock};
            `ICD_ADDR_LAST_CHAN:  regRdData <= {{(8-CH_BITS){1'b0}}, lastIdleChan};
            `ICD_ADDR_MONCFG:     regRdData <= monitorConfig;
            default:              regRdData <= 8'h00;
         endcase
      end else begin
         regRdData <= 8'h00;
      end
   end

endmodule

`default_nettype wire

//--- verilog/icd_regs.vh
// Purpose: register offsets, field positions, reset values and interval times
//          for the idle channel detector
// Assumes: byte wide register port, registers at their own byte offsets
// Notes:   definitions only
`ifndef ICD_REGS_VH
`define ICD_REGS_VH

// register offsets
`define ICD_ADDR_CONFIG      8'h32
`define ICD_ADDR_MASK        8'h33
`define ICD_ADDR_REFERENCE   8'h34
`define ICD_ADDR_MONSTAT     8'h38
`define ICD_ADDR_IRQ_STATUS  8'h39
`define ICD_ADDR_IRQ_MASK    8'h3a
`define ICD_ADDR_UNLOCK      8'h3b
`define ICD_ADDR_LAST_CHAN   8'h3c
`define ICD_ADDR_MONCFG      8'h6f

// reset values
`define ICD_RST_CONFIG       6'h1d
`define ICD_RST_MASK         8'h00
`define ICD_RST_REFERENCE    8'h55
`define ICD_RST_MONCFG       8'hfe
`define ICD_RST_IRQ_MASK     2'h0
`define ICD_RST_UNLOCK       1'h0

// detector config fields
`define ICD_CFG_ENABLE       5
`define ICD_CFG_INTERVAL_HI  4
`define ICD_CFG_INTERVAL_LO  2
`define ICD_CFG_SOURCE       1
`define ICD_CFG_PATH         0

// monitor pin config fields and codes
`define ICD_MON_ONE_HI       7
`define ICD_MON_ONE_LO       4
`define ICD_MON_TWO_HI       3
`define ICD_MON_TWO_LO       0
`define ICD_MON_CODE_IDLE    4'h0

// interrupt status bits
`define ICD_IRQ_BECAME_IDLE  0
`define ICD_IRQ_LEFT_IDLE    1

// protection interval times in microseconds
`define ICD_T_CODE0_US       64000
`define ICD_T_CODE1_US       128000
`define ICD_T_CODE2_US       512000
`define ICD_T_CODE3_US       1000000
`define ICD_T_CODE4_US       4100000
`define ICD_T_CODE5_US       8200000
`define ICD_T_CODE6_US       32800000
`define ICD_T_CODE7_US       65500000

// one byte of a channel arrives once per pcm frame
`define ICD_FRAME_US         125

`endif
